// >>> hdl/ciopx_pkg.sv
package ciopx_pkg;
    // ==========================================
    // basic channel command codes
    localparam logic [7:0] CMD_NOOP = 8'h03;
    localparam logic [7:0] CMD_BASIC_SENSE = 8'h04;
    localparam logic [7:0] CMD_TIC = 8'h08;
    localparam logic [7:0] CMD_SENSE_ID = 8'he4;
    // ==========================================
    // virtio-specific command codes
    localparam logic [7:0] CMD_SET_QUEUE = 8'h13;
    localparam logic [7:0] CMD_DEV_RESET = 8'h33;
    localparam logic [7:0] CMD_SET_QIND = 8'h43;
    localparam logic [7:0] CMD_SET_CFGIND = 8'h53;
    localparam logic [7:0] CMD_SET_ADPIND = 8'h73;
    localparam logic [7:0] CMD_READ_FEAT = 8'h12;
    localparam logic [7:0] CMD_WRITE_FEAT = 8'h11;
    localparam logic [7:0] CMD_READ_CFG = 8'h22;
    localparam logic [7:0] CMD_WRITE_CFG = 8'h21;
    localparam logic [7:0] CMD_WRITE_STAT = 8'h31;
    localparam logic [7:0] CMD_READ_QCFG = 8'h32;
    localparam logic [7:0] CMD_SET_REV = 8'h83;
    localparam logic [7:0] CMD_READ_STAT = 8'h72;
    // ==========================================
    // identification data
    localparam logic [7:0] ID_BYTE0 = 8'hff;
    localparam int ID_LEN = 256;
    // expected payload lengths in bytes
    localparam logic [15:0] LEN_FEAT = 16'h0005;
    localparam logic [15:0] LEN_QCFG = 16'h0004;
    localparam logic [15:0] LEN_QINFO = 16'h0020;
    localparam logic [15:0] LEN_QINFO_LEG = 16'h0010;
    localparam logic [15:0] LEN_IND = 16'h0008;
    localparam logic [15:0] LEN_ADPIND = 16'h0019;
    localparam logic [15:0] LEN_STAT = 16'h0001;
    localparam logic [15:0] LEN_REVHDR = 16'h0004;
    localparam logic [15:0] LEN_NONE = 16'h0000;
    // revisions
    localparam logic [15:0] REV_LEGACY = 16'h0000;
    localparam logic [15:0] REV_MAX = 16'h0002;
    localparam logic [1:0] REV_RST = 2'h0;
    // ==========================================
    // command presented to the decoder
    typedef struct packed {
        logic [7:0] code;
        logic [15:0] count;
        logic suppressLen;
        logic [15:0] revId;
        logic [15:0] revLen;
    } ciopx_cmd_t;
    // ending status of one command
    typedef struct packed {
        logic accept;
        logic cmdReject;
        logic lenMismatch;
        logic checkCond;
    } ciopx_end_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ID = 2'b01,
        ST_DONE = 2'b10
    } ciopx_state_t;
endpackage : ciopx_pkg

// >>> hdl/ciopx_decoder.sv
// Function
// - accept no-op, basic sense, transfer in channel, sense id basic commands
// - sense id returns ff, control unit type, device id, zeros to 255
// - decode queue setup 13, device reset 33, queue indicators 43
// - decode config indicators 53, adapter indicators 73, feature read 12
// - decode feature write 11, config read 22, config write 21
// - decode status write 31, queue config read 32, revision 83, status read 72
// - config changes use classic interrupts; used buffers classic or adapter
// - unsupported codes end with unit check and command reject
// - unsuppressed length mismatch presents the length status, except for no-op and transfer in channel
// - suppressed check: short data is a check condition, long accepted
// - multi-byte fields travel big-endian both ways
// - revision payload: be16 revision, be16 length, then options
// - revision 0 legacy, 1 standard, 2 status read; 3 up reserved
// - reject unsupported revision or bad revision/length/option mix
// - non-transitional device rejects revision 0
// - reject virtio commands outside the selected revision
// - reject any second revision selection once one succeeded
// - revision unset from subchannel enable until successful set
// - transitional: early virtio command implies revision 0, later set rejected
`timescale 1ns/1ps
`default_nettype none
module ciopx_decoder #(
    parameter bit TRANSITIONAL = 1'b1,
    parameter logic [15:0] CU_TYPE = 16'h1234, // arbitrary value
    parameter logic [7:0] DEV_ID = 8'h01
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // subchannel control
    input wire logic schEnable,
    // command in
    input wire logic cmdValid,
    input wire ciopx_pkg::ciopx_cmd_t cmdIn,
    output logic cmdReady,
    // ending status
    output logic endValid,
    output ciopx_pkg::ciopx_end_t endStat,
    // identification data stream, big-endian byte order
    output logic idValid,
    output logic [7:0] idByte,
    output logic idLast,
    // negotiated transport state
    output logic [1:0] revision,
    output logic revValid,
    output logic adapterMode
);
    // ==========================================
    // decode
    ciopx_pkg::ciopx_state_t state;
    ciopx_pkg::ciopx_state_t next_state;
    logic [7:0] idIdx;
    logic take;
    logic isBasic, isVirtio, isSetRev, isSenseId, isReadStat;
    logic [15:0] expLen;
    logic legacyMode;
    logic revOk, revRej, needImplicit, implicitRej, notInRev, badCode;
    logic tooShort, lenErr, doReject, effRevValid;
    logic [1:0] effRev;
    logic adpLocked;
    assign take = cmdValid && cmdReady;
    // basic channel commands
    assign isBasic = (cmdIn.code == ciopx_pkg::CMD_NOOP) ||
        (cmdIn.code == ciopx_pkg::CMD_BASIC_SENSE) ||
        (cmdIn.code == ciopx_pkg::CMD_TIC) || isSenseId;
    assign isSenseId = cmdIn.code == ciopx_pkg::CMD_SENSE_ID;
    assign isSetRev = cmdIn.code == ciopx_pkg::CMD_SET_REV;
    assign isReadStat = cmdIn.code == ciopx_pkg::CMD_READ_STAT;
    // virtio-specific codes; decoded apart from the length table so that the
    // legacy length choice cannot loop back through this decode
    assign isVirtio = cmdIn.code inside {ciopx_pkg::CMD_SET_QUEUE, ciopx_pkg::CMD_DEV_RESET,
        ciopx_pkg::CMD_SET_QIND, ciopx_pkg::CMD_SET_CFGIND, ciopx_pkg::CMD_SET_ADPIND,
        ciopx_pkg::CMD_READ_FEAT, ciopx_pkg::CMD_WRITE_FEAT, ciopx_pkg::CMD_READ_CFG,
        ciopx_pkg::CMD_WRITE_CFG, ciopx_pkg::CMD_WRITE_STAT, ciopx_pkg::CMD_READ_QCFG,
        ciopx_pkg::CMD_SET_REV, ciopx_pkg::CMD_READ_STAT};
    // expected payload length per code
    always_comb begin
        expLen = ciopx_pkg::LEN_NONE;
        case (cmdIn.code)
            ciopx_pkg::CMD_SET_QUEUE: expLen = legacyMode ? ciopx_pkg::LEN_QINFO_LEG
                : ciopx_pkg::LEN_QINFO;
            ciopx_pkg::CMD_DEV_RESET: expLen = ciopx_pkg::LEN_NONE;
            ciopx_pkg::CMD_SET_QIND: expLen = ciopx_pkg::LEN_IND;
            ciopx_pkg::CMD_SET_CFGIND: expLen = ciopx_pkg::LEN_IND;
            ciopx_pkg::CMD_SET_ADPIND: expLen = ciopx_pkg::LEN_ADPIND;
            ciopx_pkg::CMD_READ_FEAT: expLen = ciopx_pkg::LEN_FEAT;
            ciopx_pkg::CMD_WRITE_FEAT: expLen = ciopx_pkg::LEN_FEAT;
            ciopx_pkg::CMD_READ_CFG: expLen = cmdIn.count;
            ciopx_pkg::CMD_WRITE_CFG: expLen = cmdIn.count;
            ciopx_pkg::CMD_WRITE_STAT: expLen = ciopx_pkg::LEN_STAT;
            ciopx_pkg::CMD_READ_QCFG: expLen = ciopx_pkg::LEN_QCFG;
            ciopx_pkg::CMD_SET_REV: expLen = ciopx_pkg::LEN_REVHDR + cmdIn.revLen;
            ciopx_pkg::CMD_READ_STAT: expLen = ciopx_pkg::LEN_STAT;
            default: expLen = ciopx_pkg::LEN_NONE;
        endcase
        if (isSenseId) begin
            expLen = 16'(ciopx_pkg::ID_LEN);
        end
    end
    // ==========================================
    // revision handling
    // revision fields arrive already assembled from big-endian bytes
    assign revOk = (cmdIn.revLen == ciopx_pkg::LEN_NONE) &&
        (cmdIn.revId <= ciopx_pkg::REV_MAX) &&
        !((cmdIn.revId == ciopx_pkg::REV_LEGACY) && !TRANSITIONAL);
    assign revRej = isSetRev && (revValid || !revOk);
    // a virtio command ahead of any set forces legacy, or is rejected
    assign needImplicit = isVirtio && !isSetRev && !revValid;
    assign implicitRej = needImplicit && !TRANSITIONAL;
    assign effRevValid = revValid || needImplicit;
    assign effRev = revValid ? revision : ciopx_pkg::REV_RST;
    assign legacyMode = effRevValid && (effRev == 2'h0);
    // status read exists only from revision 2 on
    assign notInRev = isReadStat && (effRev < 2'h2);
    // classic queue indicators rejected once adapter ones are set
    assign adpLocked = (cmdIn.code == ciopx_pkg::CMD_SET_QIND) && adapterMode;
    assign badCode = !isBasic && !isVirtio;
    assign doReject = badCode || revRej || implicitRej || notInRev || adpLocked;
    // ==========================================
    // length checks
    assign tooShort = cmdIn.count < expLen;
    assign lenErr = !cmdIn.suppressLen && (cmdIn.count != expLen) &&
        !(cmdIn.code == ciopx_pkg::CMD_NOOP) && !(cmdIn.code == ciopx_pkg::CMD_TIC);
    // ==========================================
    // state machine: idle, identification stream, done
    assign cmdReady = (state == ciopx_pkg::ST_IDLE);
    always_comb begin
        next_state = state;
        case (state)
            ciopx_pkg::ST_IDLE: begin
                if (take && isSenseId && !lenErr && !(cmdIn.suppressLen && tooShort)) begin
                    next_state = ciopx_pkg::ST_ID;
                end else if (take) begin
                    next_state = ciopx_pkg::ST_DONE;
                end
            end
            ciopx_pkg::ST_ID: begin
                if (idIdx == 8'(ciopx_pkg::ID_LEN - 1)) begin
                    next_state = ciopx_pkg::ST_DONE;
                end
            end
            ciopx_pkg::ST_DONE: next_state = ciopx_pkg::ST_IDLE;
            default: next_state = ciopx_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state <= ciopx_pkg::ST_IDLE;
            idIdx <= 8'h00;
        end else begin
            state <= next_state;
            idIdx <= (state == ciopx_pkg::ST_ID) ? idIdx + 8'h01 : 8'h00;
        end
    end
    // identification bytes; data is registered
    logic [7:0] next_idByte;
    always_comb begin
        case (idIdx)
            8'h00: next_idByte = ciopx_pkg::ID_BYTE0;
            8'h01: next_idByte = CU_TYPE[15:8];
            8'h02: next_idByte = CU_TYPE[7:0];
            8'h03: next_idByte = DEV_ID;
            default: next_idByte = 8'h00;
        endcase
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            idValid <= 1'b0;
            idByte <= 8'h00;
            idLast <= 1'b0;
        end else begin
            idValid <= (state == ciopx_pkg::ST_ID);
            idByte <= (state == ciopx_pkg::ST_ID) ? next_idByte : 8'h00;
            idLast <= (state == ciopx_pkg::ST_ID) && (idIdx == 8'(ciopx_pkg::ID_LEN - 1));
        end
    end
    // ==========================================
    // ending status, latched when the command is taken
    ciopx_pkg::ciopx_end_t held;
    ciopx_pkg::ciopx_end_t next_held;
    always_comb begin
        next_held = '0;
        if (doReject) begin
            next_held.cmdReject = 1'b1;
        end else if (lenErr) begin
            next_held.lenMismatch = 1'b1;
        end else if (cmdIn.suppressLen && tooShort) begin
            next_held.checkCond = 1'b1;
        end else begin
            next_held.accept = 1'b1;
        end
    end
    logic good;
    assign good = next_held.accept;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            held <= '0;
        end else if (take) begin
            held <= next_held;
        end
    end
    assign endValid = (state == ciopx_pkg::ST_DONE);
    assign endStat = endValid ? held : '0;
    // ==========================================
    // negotiated state; enable discards everything, but a command accepted in
    // the same cycle is written last, so the set wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            revision <= ciopx_pkg::REV_RST;
            revValid <= 1'b0;
            adapterMode <= 1'b0;
        end else begin
            if (schEnable) begin
                revision <= ciopx_pkg::REV_RST;
                revValid <= 1'b0;
                adapterMode <= 1'b0;
            end
            if (take && good) begin
                if (isSetRev) begin
                    revision <= cmdIn.revId[1:0];
                    revValid <= 1'b1;
                end else if (needImplicit) begin
                    revision <= ciopx_pkg::REV_RST;
                    revValid <= 1'b1;
                end
                if (cmdIn.code == ciopx_pkg::CMD_SET_ADPIND) begin
                    adapterMode <= 1'b1;
                end
            end
        end
    end
    // ==========================================
    // checks
    AST_REV_ONCE: assert property (@(posedge clk) disable iff (sys_rst)
        (take && isSetRev && revValid) |=> ##0 (endValid && endStat.cmdReject))
        else $error("second revision set not rejected");
    AST_UNKNOWN: assert property (@(posedge clk) disable iff (sys_rst)
        (take && badCode) |=> (endValid && endStat.cmdReject))
        else $error("unknown code not rejected");
    AST_REV_RANGE: assert property (@(posedge clk) disable iff (sys_rst)
        (take && isSetRev && (cmdIn.revId > ciopx_pkg::REV_MAX)) |=> endStat.cmdReject)
        else $error("reserved revision accepted");
    AST_ENABLE: assert property (@(posedge clk) disable iff (sys_rst)
        (schEnable && !(take && good)) |=> (!revValid && revision == 2'h0 && !adapterMode))
        else $error("enable kept revision");
    AST_ID_FIRST: assert property (@(posedge clk) disable iff (sys_rst)
        (idValid && !$past(idValid)) |-> (idByte == ciopx_pkg::ID_BYTE0))
        else $error("sense id byte 0 wrong");
    AST_ID_TYPE: assert property (@(posedge clk) disable iff (sys_rst)
        (idValid && !$past(idValid)) |=> (idByte == CU_TYPE[15:8]) ##1 (idByte == CU_TYPE[7:0]))
        else $error("control unit type wrong");
    AST_LEN: assert property (@(posedge clk) disable iff (sys_rst)
        (take && !doReject && lenErr) |=> (endValid && endStat.lenMismatch))
        else $error("length mismatch not shown");
    AST_SHORT: assert property (@(posedge clk) disable iff (sys_rst)
        (take && !doReject && cmdIn.suppressLen && tooShort) |-> ##[1:2] endStat.checkCond)
        else $error("short data not flagged");
    AST_STATUS_REV: assert property (@(posedge clk) disable iff (sys_rst)
        (take && isReadStat && revValid && revision < 2'h2) |=> endStat.cmdReject)
        else $error("status read accepted below revision 2");
    AST_LEGACY: assert property (@(posedge clk) disable iff (sys_rst)
        (take && needImplicit && TRANSITIONAL && good) |=> (revValid && revision == 2'h0))
        else $error("implicit legacy revision missing");
    AST_ONE_END: assert property (@(posedge clk) disable iff (sys_rst)
        endValid |-> $onehot(endStat))
        else $error("ending status not exactly one bit");
    AST_ADP_LOCK: assert property (@(posedge clk) disable iff (sys_rst)
        (take && (cmdIn.code == ciopx_pkg::CMD_SET_QIND) && adapterMode) |=> endStat.cmdReject)
        else $error("classic indicators accepted after adapter ones");
    AST_NO_LEGACY: assert property (@(posedge clk) disable iff (sys_rst)
        (take && isSetRev && (cmdIn.revId == ciopx_pkg::REV_LEGACY) && !TRANSITIONAL)
        |=> endStat.cmdReject)
        else $error("revision 0 accepted without legacy support");
    AST_EARLY_STRICT: assert property (@(posedge clk) disable iff (sys_rst)
        (take && needImplicit && !TRANSITIONAL) |=> (endStat.cmdReject && !revValid))
        else $error("virtio command before revision set accepted");
endmodule : ciopx_decoder
`default_nettype wire

// >>> bench/ciopx_driver_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// guest driver model: offers one channel command at a time
module ciopx_driver_model (
    // clock
    input wire logic clk,
    // command handshake
    output logic cmdValid,
    output ciopx_pkg::ciopx_cmd_t cmdIn,
    input wire logic cmdReady,
    // ending status and identification stream
    input wire logic endValid,
    input wire ciopx_pkg::ciopx_end_t endStat,
    input wire logic idValid,
    input wire logic [7:0] idByte,
    input wire logic idLast
);
    logic [7:0] idBuf [0:255];
    int lastAt;

    // idle until the bench asks for a command
    initial begin
        cmdValid = 1'b0;
        cmdIn = '0;
    end

    // offer at a falling edge, hold until taken, then collect the whole answer
    task automatic send(input logic [7:0] code, input logic [15:0] cnt, input logic sup,
            input logic [15:0] rid, input logic [15:0] rlen,
            output ciopx_pkg::ciopx_end_t res, output int nBytes, output bit ok);
        int i;
        ok = 1'b0;
        nBytes = 0;
        res = '0;
        lastAt = -1;
        @(negedge clk);
        cmdIn <= {code, cnt, sup, rid, rlen};
        cmdValid <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (cmdReady === 1'b1) break;
        end
        @(negedge clk);
        cmdValid <= 1'b0;
        // released fields flip so stale data is never read as live
        cmdIn <= ~cmdIn;
        if (i == 16) return;
        for (i = 0; i < 400; i++) begin
            @(posedge clk);
            if (idValid === 1'b1 && nBytes < 256) begin
                idBuf[nBytes] = idByte;
                if (idLast === 1'b1) lastAt = nBytes;
                nBytes++;
            end
            if (endValid === 1'b1) begin
                res = endStat;
                ok = 1'b1;
                break;
            end
        end
    endtask : send
endmodule : ciopx_driver_model
`default_nettype wire

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
    $display("unexpected %s: expected %h, seen %h", nm, ex, got); end end
module tb_top;
    logic clk, sys_rst, schEnable, cmdValid, cmdReady, endValid, idValid, idLast;
    logic revValid, adapterMode;
    ciopx_pkg::ciopx_cmd_t cmdIn;
    ciopx_pkg::ciopx_end_t endStat;
    logic [7:0] idByte;
    logic [1:0] revision;
    logic ntRevValid;
    int err_total = 0;
    int compares = 0;
    localparam logic [15:0] CU = 16'h5a3c; // arbitrary value
    localparam logic [7:0] DEVID = 8'h07;
    // adapter indicators last: they lock out classic ones
    localparam logic [7:0] VC [12] = '{ciopx_pkg::CMD_DEV_RESET, ciopx_pkg::CMD_SET_QUEUE,
        ciopx_pkg::CMD_SET_QIND, ciopx_pkg::CMD_SET_CFGIND, ciopx_pkg::CMD_READ_FEAT,
        ciopx_pkg::CMD_WRITE_FEAT, ciopx_pkg::CMD_READ_CFG, ciopx_pkg::CMD_WRITE_CFG,
        ciopx_pkg::CMD_WRITE_STAT, ciopx_pkg::CMD_READ_QCFG, ciopx_pkg::CMD_READ_STAT,
        ciopx_pkg::CMD_SET_ADPIND};
    localparam logic [7:0] LC [5] = '{ciopx_pkg::CMD_READ_FEAT, ciopx_pkg::CMD_WRITE_FEAT,
        ciopx_pkg::CMD_READ_QCFG, ciopx_pkg::CMD_WRITE_STAT, ciopx_pkg::CMD_READ_STAT};

    // ==========================================
    // clock, device and driver
    initial clk = 1'b0;
    always #50 clk = ~clk;

    ciopx_decoder #(.TRANSITIONAL(1'b1), .CU_TYPE(CU), .DEV_ID(DEVID)) ciopx_decoder_inst (
        .clk(clk), .sys_rst(sys_rst), .schEnable(schEnable), .cmdValid(cmdValid),
        .cmdIn(cmdIn), .cmdReady(cmdReady), .endValid(endValid), .endStat(endStat),
        .idValid(idValid), .idByte(idByte), .idLast(idLast), .revision(revision),
        .revValid(revValid), .adapterMode(adapterMode));

    // a device without legacy support on the same commands; it stays in step
    // with the first one because each command takes the same number of cycles in both
    ciopx_decoder #(.TRANSITIONAL(1'b0), .CU_TYPE(CU), .DEV_ID(DEVID))
        ciopx_decoder_strict_inst (
        .clk(clk), .sys_rst(sys_rst), .schEnable(schEnable), .cmdValid(cmdValid),
        .cmdIn(cmdIn), .cmdReady(), .endValid(), .endStat(), .idValid(), .idByte(),
        .idLast(), .revision(), .revValid(ntRevValid), .adapterMode());

    ciopx_driver_model ciopx_driver_model_inst (
        .clk(clk), .cmdValid(cmdValid), .cmdIn(cmdIn), .cmdReady(cmdReady),
        .endValid(endValid), .endStat(endStat), .idValid(idValid), .idByte(idByte),
        .idLast(idLast));

    // ==========================================
    // expectations
    function automatic logic [15:0] explen(input logic [7:0] c, input logic [15:0] cnt);
        case (c)
            ciopx_pkg::CMD_READ_FEAT, ciopx_pkg::CMD_WRITE_FEAT: return ciopx_pkg::LEN_FEAT;
            ciopx_pkg::CMD_READ_QCFG: return ciopx_pkg::LEN_QCFG;
            ciopx_pkg::CMD_SET_QUEUE: return ciopx_pkg::LEN_QINFO;
            ciopx_pkg::CMD_SET_QIND, ciopx_pkg::CMD_SET_CFGIND: return ciopx_pkg::LEN_IND;
            ciopx_pkg::CMD_SET_ADPIND: return ciopx_pkg::LEN_ADPIND;
            ciopx_pkg::CMD_WRITE_STAT, ciopx_pkg::CMD_READ_STAT: return ciopx_pkg::LEN_STAT;
            ciopx_pkg::CMD_DEV_RESET: return ciopx_pkg::LEN_NONE;
            default: return cnt; // configuration space takes any length
        endcase
    endfunction : explen

    // order of precedence: length mismatch, then short data, then accept
    function automatic logic [3:0] outcome(input logic [15:0] need, input logic [15:0] cnt,
            input logic sup);
        if (!sup && cnt != need) return 4'h2;
        if (sup && cnt < need) return 4'h1;
        return 4'h8;
    endfunction : outcome

    function automatic logic [7:0] idExp(input int i);
        if (i == 0) return ciopx_pkg::ID_BYTE0;
        if (i == 1) return CU[15:8];
        if (i == 2) return CU[7:0];
        return (i == 3) ? DEVID : 8'h00;
    endfunction : idExp

    // ==========================================
    // tasks
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict

    task automatic cmd(input logic [7:0] c, input logic [15:0] cnt, input logic sup,
            input logic [15:0] rid, input logic [15:0] rlen, input logic [3:0] ex);
        ciopx_pkg::ciopx_end_t r;
        int n;
        bit ok;
        ciopx_driver_model_inst.send(c, cnt, sup, rid, rlen, r, n, ok);
        if (!ok) begin
            err_total++;
            $display("unexpected timeout: expected end status, seen none");
            give_verdict();
        end
        `CHK("end status", ex, r)
    endtask : cmd

    task automatic pulse_enable;
        @(negedge clk);
        schEnable = 1'b1;
        @(negedge clk);
        schEnable = 1'b0;
    endtask : pulse_enable

    // ==========================================
    // main sequence
    initial begin
        ciopx_pkg::ciopx_end_t r;
        bit ok;
        int i, k;
        logic [7:0] c;
        logic [15:0] n;
        sys_rst = 1'b1;
        schEnable = 1'b0;
        k = $urandom(22949);
        repeat (4) @(negedge clk);
        sys_rst = 1'b0;
        `CHK("revValid", 1'b0, revValid)
        cmd(ciopx_pkg::CMD_NOOP, 16'h0001, 1'b0, 16'h0, 16'h0, 4'h8);
        cmd(ciopx_pkg::CMD_TIC, 16'h0008, 1'b0, 16'h0, 16'h0, 4'h8);
        cmd(ciopx_pkg::CMD_BASIC_SENSE, 16'hffff, 1'b1, 16'h0, 16'h0, 4'h8);
        ciopx_driver_model_inst.send(ciopx_pkg::CMD_SENSE_ID, 16'h0100, 1'b0, 16'h0, 16'h0,
            r, k, ok);
        `CHK("sense id end", 4'h8, r)
        `CHK("sense id count", 256, k)
        `CHK("sense id last", 255, ciopx_driver_model_inst.lastAt)
        for (i = 0; i < 256; i++)
            `CHK("sense id byte", idExp(i), ciopx_driver_model_inst.idBuf[i])
        cmd(ciopx_pkg::CMD_SENSE_ID, 16'h0004, 1'b0, 16'h0, 16'h0, 4'h2);
        cmd(ciopx_pkg::CMD_SENSE_ID, 16'h0004, 1'b1, 16'h0, 16'h0, 4'h1);
        // unknown codes, random, first before any revision exists
        for (i = 0; i < 24; i++) begin
            c = (i == 0) ? 8'h00 : ((i == 1) ? 8'hff : 8'($urandom));
            if (c inside {VC, ciopx_pkg::CMD_NOOP, ciopx_pkg::CMD_BASIC_SENSE,
                ciopx_pkg::CMD_TIC, ciopx_pkg::CMD_SENSE_ID, ciopx_pkg::CMD_SET_REV}) continue;
            cmd(c, 16'($urandom), 1'($urandom), 16'h0, 16'h0, 4'h4);
        end
        // early virtio command: legacy driver assumed
        cmd(ciopx_pkg::CMD_WRITE_STAT, 16'h0001, 1'b0, 16'h0, 16'h0, 4'h8);
        `CHK("implied revision", 2'h0, revision)
        `CHK("strict revValid early", 1'b0, ntRevValid)
        cmd(ciopx_pkg::CMD_SET_QUEUE, 16'h0010, 1'b0, 16'h0, 16'h0, 4'h8);
        cmd(ciopx_pkg::CMD_READ_STAT, 16'h0001, 1'b0, 16'h0, 16'h0, 4'h4);
        cmd(ciopx_pkg::CMD_SET_REV, 16'h0004, 1'b0, 16'h2, 16'h0, 4'h4);
        pulse_enable();
        `CHK("revValid after enable", 1'b0, revValid)
        cmd(ciopx_pkg::CMD_SET_REV, 16'h0005, 1'b0, 16'h2, 16'h1, 4'h4);
        // highest revision first, lower on each reject
        for (k = 7; k > 0; k--) begin
            cmd(ciopx_pkg::CMD_SET_REV, 16'h0004, 1'b0, 16'(k), 16'h0, (k > 2) ? 4'h4 : 4'h8);
            if (k == 2) break;
        end
        `CHK("revision", 2'h2, revision)
        `CHK("revValid", 1'b1, revValid)
        cmd(ciopx_pkg::CMD_SET_REV, 16'h0004, 1'b0, 16'h1, 16'h0, 4'h4);
        `CHK("revision kept", 2'h2, revision)
        for (i = 0; i < 12; i++) begin
            n = 16'($urandom_range(1, 64));
            cmd(VC[i], explen(VC[i], n), 1'(i % 2), 16'h0, 16'h0, 4'h8);
        end
        `CHK("adapterMode", 1'b1, adapterMode)
        cmd(ciopx_pkg::CMD_SET_QIND, 16'h0008, 1'b0, 16'h0, 16'h0, 4'h4);
        // random lengths around the expected size, checks on and off
        for (i = 0; i < 30; i++) begin
            c = LC[$urandom_range(0, 4)];
            n = explen(c, 16'h0) + 16'($urandom_range(0, 4)) - 16'h2;
            k = $urandom_range(0, 1);
            cmd(c, n, 1'(k), 16'h0, 16'h0, outcome(explen(c, 16'h0), n, 1'(k)));
        end
        pulse_enable();
        `CHK("adapterMode after enable", 1'b0, adapterMode)
        cmd(ciopx_pkg::CMD_SET_REV, 16'h0004, 1'b0, 16'h0, 16'h0, 4'h8);
        `CHK("revValid legacy", 1'b1, revValid)
        `CHK("strict revValid legacy", 1'b0, ntRevValid)
        cmd(ciopx_pkg::CMD_READ_STAT, 16'h0001, 1'b0, 16'h0, 16'h0, 4'h4);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
